/* pdwg_pkg.sv */
package pdwg_pkg;
  // bit positions inside the software write data words
  localparam int BROWNOUT_FLAG_BIT    = 4;
  localparam int SUPPLY_VOLTAGE_DETECTOR_FLAG_BIT        = 19;
  localparam int TIMER_IRQ_BIT        = 0;
  localparam int TIMER_WAKE_BIT       = 1;
  localparam int WDOG_WAKE_BIT        = 5;
  localparam int ALARM_BIT            = 0;
  localparam int TICK_BIT             = 1;
  localparam int USU_WAKE_BIT         = 0;
  localparam int TW_WAKE_BIT          = 0;
  localparam int TW_ACK_BIT           = 1;
  localparam int USU_ACK_BIT          = 16;
  localparam int CMP_A_BIT            = 8;
  localparam int CMP_B_BIT            = 9;
  localparam int PWR_REQ_BIT          = 7;
  // group widths
  localparam int PIN_W                = 16;
  localparam int UART_W               = 5;
  localparam int NSRC                 = 13;
  // source indices in the flag bank
  localparam int S_BOD = 0;
  localparam int S_SUPPLY_VOLTAGE_DETECTOR = 1;
  localparam int S_TWK = 2;
  localparam int S_TIF = 3;
  localparam int S_WDT = 4;
  localparam int S_ALM = 5;
  localparam int S_TICK = 6;
  localparam int S_UUART = 7;
  localparam int S_UI2C = 8;
  localparam int S_USPI = 9;
  localparam int S_I2C = 10;
  localparam int S_CMPA = 11;
  localparam int S_CMPB = 12;

  typedef enum logic [1:0] {
    PD_NORMAL = 2'b00,
    PD_DOWN   = 2'b01
  } pdwg_state_t;
endpackage

/* pdwg_flag_if.sv */
// one bank of sticky wake flags: set strobes, clear strobes, held state
interface pdwg_flag_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

/* pdwg_flag_bank.sv */
// sticky flags: a set in the same cycle as a clear wins
module pdwg_flag_bank #(
  parameter int W = 1
) (
  input  wire logic   clk,
  input  wire logic   rst,
  pdwg_flag_if.owner  fl
);
  logic [W-1:0] q_reg;

  // write-one-to-clear; zero writes leave bits alone
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q_reg <= '0;
    else
      q_reg <= (q_reg & ~fl.clr) | fl.set;
  end

  assign fl.q = q_reg;
endmodule

/* pdwg_top.sv */
module pdwg_top (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // power control
  input  wire logic                       SLEEP_MODE_ENABLE,
  input  wire logic                       POWER_DOWN_REQUEST_ENABLE,
  input  wire logic                       SLEEP_INSTRUCTION,
  input  wire logic                       WRITE_PROTECT_OPEN,
  // wake and acknowledge events from sources, one-cycle pulses
  input  wire logic                       BROWNOUT_EVENT,
  input  wire logic                       SUPPLY_VOLTAGE_DETECTOR_EVENT,
  input  wire logic [pdwg_pkg::PIN_W-1:0] PIN_EVENT,
  input  wire logic                       TIMER_WAKE_EVENT,
  input  wire logic                       TIMER_IRQ_EVENT,
  input  wire logic                       WATCHDOG_EVENT,
  input  wire logic                       ALARM_EVENT,
  input  wire logic                       TICK_EVENT,
  input  wire logic [pdwg_pkg::UART_W-1:0] UART_EVENT,
  input  wire logic                       USU_ASYNC_EVENT,
  input  wire logic                       USU_TWOWIRE_EVENT,
  input  wire logic                       USU_ACK_EVENT,
  input  wire logic                       USU_SYNC_EVENT,
  input  wire logic                       TWOWIRE_EVENT,
  input  wire logic                       TWOWIRE_ACK_EVENT,
  input  wire logic                       CMP_A_EVENT,
  input  wire logic                       CMP_B_EVENT,
  // software write-one-to-clear strobes, one cycle with data
  input  wire logic                       BROWNOUT_CONTROL_WR,
  input  wire logic [31:0]                BROWNOUT_CONTROL_WDATA,
  input  wire logic                       PORT_SRC_WR,
  input  wire logic [pdwg_pkg::PIN_W-1:0] PORT_SRC_WDATA,
  input  wire logic                       TIMER_STATUS_WR,
  input  wire logic [1:0]                 TIMER_STATUS_WDATA,
  input  wire logic                       WATCHDOG_CONTROL_WR,
  input  wire logic [7:0]                 WATCHDOG_CONTROL_WDATA,
  input  wire logic                       CAL_STATUS_WR,
  input  wire logic [1:0]                 CAL_STATUS_WDATA,
  input  wire logic                       UART_WAKE_WR,
  input  wire logic [pdwg_pkg::UART_W-1:0] UART_WAKE_WDATA,
  input  wire logic                       USU_ASYNC_WR,
  input  wire logic                       USU_TWOWIRE_WR,
  input  wire logic                       USU_PROT_WR,
  input  wire logic [31:0]                USU_PROT_WDATA,
  input  wire logic                       USU_SYNC_WR,
  input  wire logic [0:0]                 USU_WDATA,
  input  wire logic                       TWOWIRE_WAKE_WR,
  input  wire logic [1:0]                 TWOWIRE_WAKE_WDATA,
  input  wire logic                       CMP_STATUS_WR,
  input  wire logic [15:0]                CMP_STATUS_WDATA,
  // status
  output logic                            POWER_DOWN,
  output logic                            WAKE_PENDING,
  output logic                            ENTRY_BLOCKED,
  output logic [pdwg_pkg::NSRC-1:0]       WAKE_FLAGS,
  output logic [pdwg_pkg::PIN_W-1:0]      PIN_FLAGS,
  output logic [pdwg_pkg::UART_W-1:0]     UART_FLAGS,
  output logic                            USU_ACK_DONE,
  output logic                            TWOWIRE_ACK_DONE
);
  pdwg_pkg::pdwg_state_t state_reg;
  pdwg_pkg::pdwg_state_t state_next;
  logic       any_flag;
  logic       entry_req;
  logic [1:0] ack_q;
  logic [1:0] ack_set;
  logic [1:0] ack_clr;

  pdwg_flag_if #(.W(pdwg_pkg::NSRC))   src_f ();
  pdwg_flag_if #(.W(pdwg_pkg::PIN_W))  pin_f ();
  pdwg_flag_if #(.W(pdwg_pkg::UART_W)) uart_f ();
  pdwg_flag_if #(.W(2))                ack_f ();

  // single-source flag set strobes
  always_comb
  begin
    src_f.set = '0;
    src_f.set[pdwg_pkg::S_BOD]   = BROWNOUT_EVENT;
    src_f.set[pdwg_pkg::S_SUPPLY_VOLTAGE_DETECTOR]  = SUPPLY_VOLTAGE_DETECTOR_EVENT;
    src_f.set[pdwg_pkg::S_TWK]   = TIMER_WAKE_EVENT;
    src_f.set[pdwg_pkg::S_TIF]   = TIMER_IRQ_EVENT;
    src_f.set[pdwg_pkg::S_WDT]   = WATCHDOG_EVENT;
    src_f.set[pdwg_pkg::S_ALM]   = ALARM_EVENT;
    src_f.set[pdwg_pkg::S_TICK]  = TICK_EVENT;
    src_f.set[pdwg_pkg::S_UUART] = USU_ASYNC_EVENT;
    src_f.set[pdwg_pkg::S_UI2C]  = USU_TWOWIRE_EVENT;
    src_f.set[pdwg_pkg::S_USPI]  = USU_SYNC_EVENT;
    src_f.set[pdwg_pkg::S_I2C]   = TWOWIRE_EVENT;
    src_f.set[pdwg_pkg::S_CMPA]  = CMP_A_EVENT;
    src_f.set[pdwg_pkg::S_CMPB]  = CMP_B_EVENT;
  end

  // single-source clear strobes, only where a one is written
  always_comb
  begin
    src_f.clr = '0;
    src_f.clr[pdwg_pkg::S_BOD]  = BROWNOUT_CONTROL_WR &
                                  BROWNOUT_CONTROL_WDATA[pdwg_pkg::BROWNOUT_FLAG_BIT];
    src_f.clr[pdwg_pkg::S_SUPPLY_VOLTAGE_DETECTOR] = BROWNOUT_CONTROL_WR &
                                  BROWNOUT_CONTROL_WDATA[pdwg_pkg::SUPPLY_VOLTAGE_DETECTOR_FLAG_BIT];
    src_f.clr[pdwg_pkg::S_TWK]  = TIMER_STATUS_WR &
                                  TIMER_STATUS_WDATA[pdwg_pkg::TIMER_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_TIF]  = TIMER_STATUS_WR &
                                  TIMER_STATUS_WDATA[pdwg_pkg::TIMER_IRQ_BIT];
    src_f.clr[pdwg_pkg::S_WDT]  = WATCHDOG_CONTROL_WR & WRITE_PROTECT_OPEN &
                                  WATCHDOG_CONTROL_WDATA[pdwg_pkg::WDOG_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_ALM]  = CAL_STATUS_WR &
                                  CAL_STATUS_WDATA[pdwg_pkg::ALARM_BIT];
    src_f.clr[pdwg_pkg::S_TICK] = CAL_STATUS_WR &
                                  CAL_STATUS_WDATA[pdwg_pkg::TICK_BIT];
    src_f.clr[pdwg_pkg::S_UUART] = USU_ASYNC_WR &
                                   USU_WDATA[pdwg_pkg::USU_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_UI2C]  = USU_TWOWIRE_WR &
                                   USU_WDATA[pdwg_pkg::USU_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_USPI]  = USU_SYNC_WR &
                                   USU_WDATA[pdwg_pkg::USU_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_I2C]   = TWOWIRE_WAKE_WR &
                                   TWOWIRE_WAKE_WDATA[pdwg_pkg::TW_WAKE_BIT];
    src_f.clr[pdwg_pkg::S_CMPA]  = CMP_STATUS_WR &
                                   CMP_STATUS_WDATA[pdwg_pkg::CMP_A_BIT];
    src_f.clr[pdwg_pkg::S_CMPB]  = CMP_STATUS_WR &
                                   CMP_STATUS_WDATA[pdwg_pkg::CMP_B_BIT];
  end

  // pin pending and serial port wake groups
  always_comb
  begin
    pin_f.set  = PIN_EVENT;
    pin_f.clr  = PORT_SRC_WR ? PORT_SRC_WDATA : '0;
    uart_f.set = UART_EVENT;
    uart_f.clr = UART_WAKE_WR ? UART_WAKE_WDATA : '0;
  end

  // wake-acknowledge-done bits, informational, not part of the wake set
  always_comb
  begin
    ack_set = {TWOWIRE_ACK_EVENT, USU_ACK_EVENT};
    ack_clr = {TWOWIRE_WAKE_WR & TWOWIRE_WAKE_WDATA[pdwg_pkg::TW_ACK_BIT],
               USU_PROT_WR & USU_PROT_WDATA[pdwg_pkg::USU_ACK_BIT]};
    ack_f.set = ack_set;
    ack_f.clr = ack_clr;
  end
  assign ack_q = ack_f.q;

  pdwg_flag_bank #(.W(pdwg_pkg::NSRC)) u_src (
    .clk (CLK),
    .rst (RST),
    .fl  (src_f)
  );

  pdwg_flag_bank #(.W(pdwg_pkg::PIN_W)) u_pin (
    .clk (CLK),
    .rst (RST),
    .fl  (pin_f)
  );

  pdwg_flag_bank #(.W(pdwg_pkg::UART_W)) u_uart (
    .clk (CLK),
    .rst (RST),
    .fl  (uart_f)
  );

  pdwg_flag_bank #(.W(2)) u_ack (
    .clk (CLK),
    .rst (RST),
    .fl  (ack_f)
  );

  // merged pending, counting also events arriving this cycle
  assign any_flag = (|src_f.q) | (|pin_f.q) | (|uart_f.q) |
                    (|src_f.set) | (|pin_f.set) | (|uart_f.set);

  // entry needs all three conditions and no pending wake
  assign entry_req = SLEEP_MODE_ENABLE & POWER_DOWN_REQUEST_ENABLE &
                     SLEEP_INSTRUCTION;

  // power mode sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pdwg_pkg::PD_NORMAL:
      begin
        if (entry_req && !any_flag)
          state_next = pdwg_pkg::PD_DOWN;
      end
      pdwg_pkg::PD_DOWN:
      begin
        if (any_flag)
          state_next = pdwg_pkg::PD_NORMAL;
      end
      default:
        state_next = pdwg_pkg::PD_NORMAL;
    endcase
  end

  // state register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_reg <= pdwg_pkg::PD_NORMAL;
    else
      state_reg <= state_next;
  end

  // registered status outputs
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      POWER_DOWN       <= 1'b0;
      WAKE_PENDING     <= 1'b0;
      ENTRY_BLOCKED    <= 1'b0;
      WAKE_FLAGS       <= '0;
      PIN_FLAGS        <= '0;
      UART_FLAGS       <= '0;
      USU_ACK_DONE     <= 1'b0;
      TWOWIRE_ACK_DONE <= 1'b0;
    end
    else
    begin
      POWER_DOWN       <= (state_next == pdwg_pkg::PD_DOWN);
      WAKE_PENDING     <= any_flag;
      ENTRY_BLOCKED    <= any_flag;
      WAKE_FLAGS       <= (src_f.q & ~src_f.clr) | src_f.set;
      PIN_FLAGS        <= (pin_f.q & ~pin_f.clr) | pin_f.set;
      UART_FLAGS       <= (uart_f.q & ~uart_f.clr) | uart_f.set;
      USU_ACK_DONE     <= (ack_q[0] & ~ack_clr[0]) | ack_set[0];
      TWOWIRE_ACK_DONE <= (ack_q[1] & ~ack_clr[1]) | ack_set[1];
    end
  end
endmodule

/* pdwg_top_properties.sv */
module pdwg_top_properties (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // power control
  input wire logic        SLEEP_MODE_ENABLE,
  input wire logic        POWER_DOWN_REQUEST_ENABLE,
  input wire logic        SLEEP_INSTRUCTION,
  input wire logic        WRITE_PROTECT_OPEN,
  // wake events and clear strobes
  input wire logic        BROWNOUT_EVENT,
  input wire logic        SUPPLY_VOLTAGE_DETECTOR_EVENT,
  input wire logic [15:0] PIN_EVENT,
  input wire logic [4:0]  UART_EVENT,
  input wire logic        BROWNOUT_CONTROL_WR,
  input wire logic [31:0] BROWNOUT_CONTROL_WDATA,
  input wire logic        PORT_SRC_WR,
  input wire logic [15:0] PORT_SRC_WDATA,
  // status
  input wire logic        POWER_DOWN,
  input wire logic [12:0] WAKE_FLAGS,
  input wire logic [15:0] PIN_FLAGS,
  input wire logic [4:0]  UART_FLAGS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // any sticky flag still held
  sequence s_flag_any;
    (|WAKE_FLAGS) || (|PIN_FLAGS) || (|UART_FLAGS);
  endsequence
  // a wake event arriving while powered down
  sequence s_wake_in_pd;
    POWER_DOWN && (BROWNOUT_EVENT || SUPPLY_VOLTAGE_DETECTOR_EVENT || (|PIN_EVENT) || (|UART_EVENT));
  endsequence
  property p_entry_needs_all;
    !POWER_DOWN && !(SLEEP_MODE_ENABLE && POWER_DOWN_REQUEST_ENABLE && SLEEP_INSTRUCTION)
      |=> !POWER_DOWN;
  endproperty
  property p_entry_blocked;
    s_flag_any |=> !$rose(POWER_DOWN);
  endproperty
  property p_wake_exit;
    s_wake_in_pd |=> !POWER_DOWN;
  endproperty
  property p_bod_set;
    BROWNOUT_EVENT |=> WAKE_FLAGS[0] && !POWER_DOWN;
  endproperty
  property p_bod_hold;
    WAKE_FLAGS[0] && !(BROWNOUT_CONTROL_WR && BROWNOUT_CONTROL_WDATA[4]) |=> WAKE_FLAGS[0];
  endproperty
  property p_supply_voltage_detector_clear;
    BROWNOUT_CONTROL_WR && BROWNOUT_CONTROL_WDATA[19] && !SUPPLY_VOLTAGE_DETECTOR_EVENT |=> !WAKE_FLAGS[1];
  endproperty
  property p_wdt_locked;
    WAKE_FLAGS[4] && !WRITE_PROTECT_OPEN |=> WAKE_FLAGS[4];
  endproperty
  property p_pin_clear;
    PORT_SRC_WR && PIN_EVENT == 16'h0000 |=> (PIN_FLAGS & $past(PORT_SRC_WDATA)) == 16'h0000;
  endproperty
  property p_uart_set;
    |UART_EVENT |=> (UART_FLAGS & $past(UART_EVENT)) == $past(UART_EVENT);
  endproperty
  a_entry_needs_all: assert property (p_entry_needs_all)
    else $error("power-down entered without full command");
  a_entry_blocked: assert property (p_entry_blocked)
    else $error("power-down entered with a flag held");
  a_wake_exit: assert property (p_wake_exit)
    else $error("wake event did not leave power-down");
  a_bod_set: assert property (p_bod_set)
    else $error("brown-out flag not set");
  a_bod_hold: assert property (p_bod_hold)
    else $error("brown-out flag dropped without clear");
  a_supply_voltage_detector_clear: assert property (p_supply_voltage_detector_clear)
    else $error("voltage flag not cleared");
  a_wdt_locked: assert property (p_wdt_locked)
    else $error("watchdog flag cleared while locked");
  a_pin_clear: assert property (p_pin_clear)
    else $error("pin flag not cleared");
  a_uart_set: assert property (p_uart_set)
    else $error("serial flag not set");
endmodule

/* test_pdwg_top.sv */
module test_pdwg_top;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs, all given a value at time zero
  logic CLK = '0, RST = '1, SLEEP_MODE_ENABLE = '0, POWER_DOWN_REQUEST_ENABLE = '0;
  logic SLEEP_INSTRUCTION = '0, WRITE_PROTECT_OPEN = '1, BROWNOUT_EVENT = '0, SUPPLY_VOLTAGE_DETECTOR_EVENT = '0;
  logic TIMER_WAKE_EVENT = '0, TIMER_IRQ_EVENT = '0, WATCHDOG_EVENT = '0, ALARM_EVENT = '0;
  logic TICK_EVENT = '0, USU_ASYNC_EVENT = '0, USU_TWOWIRE_EVENT = '0, USU_ACK_EVENT = '0;
  logic USU_SYNC_EVENT = '0, TWOWIRE_EVENT = '0, TWOWIRE_ACK_EVENT = '0, CMP_A_EVENT = '0;
  logic CMP_B_EVENT = '0, BROWNOUT_CONTROL_WR = '0, PORT_SRC_WR = '0, TIMER_STATUS_WR = '0;
  logic WATCHDOG_CONTROL_WR = '0, CAL_STATUS_WR = '0, UART_WAKE_WR = '0, USU_ASYNC_WR = '0;
  logic USU_TWOWIRE_WR = '0, USU_PROT_WR = '0, USU_SYNC_WR = '0, TWOWIRE_WAKE_WR = '0;
  logic CMP_STATUS_WR = '0;
  logic [15:0] PIN_EVENT = '0, PORT_SRC_WDATA = '0, CMP_STATUS_WDATA = '0;
  logic [4:0]  UART_EVENT = '0, UART_WAKE_WDATA = '0;
  logic [31:0] BROWNOUT_CONTROL_WDATA = '0, USU_PROT_WDATA = 32'h00010000;
  logic [1:0]  TIMER_STATUS_WDATA = '0, CAL_STATUS_WDATA = '0, TWOWIRE_WAKE_WDATA = '0;
  logic [7:0]  WATCHDOG_CONTROL_WDATA = 8'h20;
  logic [0:0]  USU_WDATA = 1'h1;
  // design outputs
  logic        POWER_DOWN, WAKE_PENDING, ENTRY_BLOCKED, USU_ACK_DONE, TWOWIRE_ACK_DONE;
  logic [12:0] WAKE_FLAGS;
  logic [15:0] PIN_FLAGS;
  logic [4:0]  UART_FLAGS;
  int          errors = 0, n_checks = 0;
  pdwg_top dut (.*);
  // free-running clock
  always #2 CLK = ~CLK;
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic results;
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // drive the thirteen single wake events in flag-bank order
  task automatic evs(input logic [12:0] v);
    {CMP_B_EVENT, CMP_A_EVENT, TWOWIRE_EVENT, USU_SYNC_EVENT, USU_TWOWIRE_EVENT,
     USU_ASYNC_EVENT, TICK_EVENT, ALARM_EVENT, WATCHDOG_EVENT, TIMER_IRQ_EVENT,
     TIMER_WAKE_EVENT, SUPPLY_VOLTAGE_DETECTOR_EVENT, BROWNOUT_EVENT} <= v;
  endtask
  // one clear strobe with its data, by source index
  task automatic wr(input int i, input logic v);
    case (i)
      0: {BROWNOUT_CONTROL_WR, BROWNOUT_CONTROL_WDATA} <= {v, 32'h00000010};
      1: {BROWNOUT_CONTROL_WR, BROWNOUT_CONTROL_WDATA} <= {v, 32'h00080000};
      2: {TIMER_STATUS_WR, TIMER_STATUS_WDATA} <= {v, 2'h2};
      3: {TIMER_STATUS_WR, TIMER_STATUS_WDATA} <= {v, 2'h1};
      4: WATCHDOG_CONTROL_WR <= v;
      5: {CAL_STATUS_WR, CAL_STATUS_WDATA} <= {v, 2'h1};
      6: {CAL_STATUS_WR, CAL_STATUS_WDATA} <= {v, 2'h2};
      7: USU_ASYNC_WR <= v;
      8: USU_TWOWIRE_WR <= v;
      9: USU_SYNC_WR <= v;
      10: {TWOWIRE_WAKE_WR, TWOWIRE_WAKE_WDATA} <= {v, 2'h1};
      11: {CMP_STATUS_WR, CMP_STATUS_WDATA} <= {v, 16'h0100};
      default: {CMP_STATUS_WR, CMP_STATUS_WDATA} <= {v, 16'h0200};
    endcase
  endtask
  // one-cycle clear of one source
  task automatic clr(input int i);
    @(posedge CLK) wr(i, 1'h1);
    @(posedge CLK) wr(i, 1'h0);
  endtask
  // set the enables, sleep instruction for one cycle, then look at the mode
  task automatic try_sleep(input logic [2:0] en, input logic exp);
    @(posedge CLK) {SLEEP_MODE_ENABLE, POWER_DOWN_REQUEST_ENABLE, SLEEP_INSTRUCTION} <= en;
    @(posedge CLK) SLEEP_INSTRUCTION <= 1'h0;
    #1 chk(POWER_DOWN, exp);
  endtask
  // every source set at once, then cleared one by one
  task automatic t_sources;
    logic [12:0] m;
    m = 13'h1FFF;
    @(posedge CLK) evs(13'h1FFF);
    @(posedge CLK) evs(13'h0000);
    #1 chk(WAKE_FLAGS, m);
    chk(ENTRY_BLOCKED, 1'h1);
    chk(WAKE_PENDING, 1'h1);
    for (int i = 0; i < 13; i++)
    begin
      clr(i);
      m[i] = 1'h0;
      #1 chk(WAKE_FLAGS, m);
    end
    @(posedge CLK) #1 chk(WAKE_PENDING, 1'h0);
    chk(ENTRY_BLOCKED, 1'h0);
  endtask
  // set beats clear, locked watchdog clear is ignored
  task automatic t_guard;
    @(posedge CLK) evs(13'h0011);
    wr(0, 1'h1);
    WRITE_PROTECT_OPEN <= 1'h0;
    @(posedge CLK) evs(13'h0000);
    wr(0, 1'h0);
    wr(4, 1'h1);
    @(posedge CLK) wr(4, 1'h0);
    #1 chk(WAKE_FLAGS, 13'h0011);
    @(posedge CLK) WRITE_PROTECT_OPEN <= 1'h1;
    clr(4);
    clr(0);
    #1 chk(WAKE_FLAGS, 13'h0000);
  endtask
  // entry, wake by pin and serial port, blocked re-entry
  task automatic t_power;
    for (int k = 0; k < 3; k++) try_sleep(~(3'h1 << k), 1'h0);
    try_sleep(3'h7, 1'h1);
    repeat (3) @(posedge CLK);
    @(posedge CLK) PIN_EVENT <= 16'h8001;
    @(posedge CLK) PIN_EVENT <= 16'h0000;
    #1 chk(POWER_DOWN, 1'h0);
    try_sleep(3'h7, 1'h0);
    @(posedge CLK) {PORT_SRC_WR, PORT_SRC_WDATA} <= {1'h1, 16'h7FFE};
    @(posedge CLK) PORT_SRC_WDATA <= 16'h0001;
    @(posedge CLK) PORT_SRC_WDATA <= 16'h8000;
    #1 chk(PIN_FLAGS, 16'h8000);
    @(posedge CLK) PORT_SRC_WR <= 1'h0;
    repeat (2) @(posedge CLK);
    try_sleep(3'h7, 1'h1);
    @(posedge CLK) UART_EVENT <= 5'h11;
    @(posedge CLK) {UART_EVENT, UART_WAKE_WR, UART_WAKE_WDATA} <= {5'h00, 1'h1, 5'h01};
    #1 chk({POWER_DOWN, UART_FLAGS}, 6'h11);
    @(posedge CLK) UART_WAKE_WDATA <= 5'h10;
    #1 chk(UART_FLAGS, 5'h10);
    @(posedge CLK) UART_WAKE_WR <= 1'h0;
    #1 chk(UART_FLAGS, 5'h00);
  endtask
  // two-wire wakes from power-down, ack bits cleared ahead of their wake flags
  task automatic t_ack;
    try_sleep(3'h7, 1'h1);
    @(posedge CLK) {USU_ACK_EVENT, TWOWIRE_ACK_EVENT} <= 2'h3;
    evs(13'h0500);
    @(posedge CLK) {USU_ACK_EVENT, TWOWIRE_ACK_EVENT, USU_PROT_WR} <= 3'h1;
    evs(13'h0000);
    #1 chk({POWER_DOWN, USU_ACK_DONE, TWOWIRE_ACK_DONE}, 3'h3);
    chk(WAKE_FLAGS, 13'h0500);
    @(posedge CLK) {USU_PROT_WR, TWOWIRE_WAKE_WR, TWOWIRE_WAKE_WDATA} <= 4'h6;
    #1 chk(USU_ACK_DONE, 1'h0);
    @(posedge CLK) TWOWIRE_WAKE_WR <= 1'h0;
    #1 chk(TWOWIRE_ACK_DONE, 1'h0);
    clr(8);
    clr(10);
    #1 chk(WAKE_FLAGS, 13'h0000);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge CLK);
    RST <= 1'h0;
    #1 chk({POWER_DOWN, WAKE_PENDING, WAKE_FLAGS, PIN_FLAGS, UART_FLAGS}, 64'h0);
    t_sources();
    t_guard();
    t_power();
    t_ack();
    results();
  end
  // hang guard, far beyond the roughly 80 cycles the tests need
  initial
  begin
    #20000;
    errors++;
    results();
  end
endmodule
bind pdwg_top pdwg_top_properties chk_i (.*);
